// File: rtl/rsc_pkg.sv
package rsc_pkg;
    // ********************
    // selector values
    // ********************
    localparam logic [1:0] RUN_SRC_KEYPAD = 2'h0;
    localparam logic [1:0] RUN_SRC_CONTACT = 2'h1;
    localparam logic [1:0] RUN_SRC_RESET = 2'h0;
    localparam logic [3:0] FREQ_SRC_KEYPAD = 4'h0;
    localparam logic [3:0] FREQ_SRC_REMOTE = 4'h3;
    localparam logic [3:0] FREQ_SRC_REMOTE_MAX = 4'h4;
    localparam logic [3:0] FREQ_SRC_RESET = 4'h0;
    localparam logic [1:0] LINK_FUNC_RESET = 2'h0;
    localparam int LINK_FUNC_OP_BIT = 1;
    localparam logic REV_INHIBIT_ON = 1'b1;
    localparam logic STOP_RAMP = 1'b0;

    // ********************
    // serial link
    // ********************
    localparam logic [7:0] STATION_ADDR_RESET = 8'h01;
    localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
    localparam logic [15:0] CMD_WORD_ADDR = 16'h0706;
    localparam int CMD_FWD_BIT = 0;
    localparam int CMD_REV_BIT = 1;
    localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam int FRAME_BYTES = 8;
    localparam int CLK_HZ = 50000000;
    localparam int BAUD_DEFAULT = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
    localparam int GAP_BITS = 35;

    // ********************
    // backlight
    // ********************
    localparam int BACKLIGHT_MINUTES = 5;
    localparam longint BACKLIGHT_CYCLES = 64'(BACKLIGHT_MINUTES) * 64'd60 * 64'(CLK_HZ);

    // ********************
    // displayed state and mode
    // ********************
    typedef enum logic [2:0]
    {
        ST_STOP = 3'b001,
        ST_FWD = 3'b010,
        ST_REV = 3'b100
    } rsc_run_t;

    typedef enum logic [3:0]
    {
        MODE_TERMINAL = 4'b0001,
        MODE_KEYPAD = 4'b0010,
        MODE_SERIAL = 4'b0100,
        MODE_JOG = 4'b1000
    } rsc_mode_t;

    typedef struct packed
    {
        logic forward_key;
        logic reverse_key;
        logic stop_key;
        logic reset_key;
        logic up_key;
        logic menu_key;
    } rsc_keys_t;

    typedef struct packed
    {
        logic [1:0] run_source_select;
        logic [3:0] frequency_source_select;
        logic [1:0] serial_link_function;
        logic reverse_inhibit;
        logic stop_method_select;
        logic [7:0] station_addr;
    } rsc_cfg_t;
endpackage

// File: rtl/rsc_rx.sv
`timescale 1ns/1ps
// serial receiver: 8N1 bytes, frame gap, crc16 over each frame
module rsc_rx #(
    parameter int BIT_CYCLES = rsc_pkg::BIT_CYCLES
)(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic rxd,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic frame_gap,
    output logic [15:0] crc
);
    typedef struct packed
    {
        logic [2:0] sync;
        logic busy;
        logic [15:0] cnt;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic bv;
        logic [7:0] bd;
        logic [23:0] idle;
        logic gap;
        logic [15:0] crc;
    } rsc_rx_t;

    rsc_rx_t s_r, s_nxt;

    // crc16 step over one byte
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
        begin
            x = x[0] ? ((x >> 1) ^ rsc_pkg::CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    // ********************
    // next state
    // ********************
    always_comb
    begin
        logic line;
        s_nxt = s_r;
        s_nxt.sync = {s_r.sync[1:0], rxd};
        line = s_r.sync[2];
        s_nxt.bv = 1'b0;
        s_nxt.gap = 1'b0;
        if (!s_r.busy)
        begin
            if (s_r.sync[2] == s_r.sync[1] && !line)
            begin
                s_nxt.busy = 1'b1;
                s_nxt.cnt = 16'(BIT_CYCLES / 2);
                s_nxt.bitn = 4'h0;
                s_nxt.idle = 24'h0000_00;
            end
            else if (s_r.idle == 24'(BIT_CYCLES * rsc_pkg::GAP_BITS))
            begin
                s_nxt.gap = 1'b1; // frame ended
                s_nxt.idle = s_r.idle + 24'h0000_01;
                s_nxt.crc = rsc_pkg::CRC_INIT;
            end
            else if (s_r.idle < 24'(BIT_CYCLES * rsc_pkg::GAP_BITS))
            begin
                s_nxt.idle = s_r.idle + 24'h0000_01;
            end
        end
        else if (s_r.cnt != 16'h0000)
        begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
        end
        else
        begin
            s_nxt.cnt = 16'(BIT_CYCLES - 1);
            s_nxt.bitn = s_r.bitn + 4'h1;
            if (s_r.bitn == 4'h0 && line)
            begin
                s_nxt.busy = 1'b0; // false start
            end
            else if (s_r.bitn >= 4'h1 && s_r.bitn <= 4'h8)
            begin
                s_nxt.sh = {line, s_r.sh[7:1]};
            end
            else if (s_r.bitn == 4'h9)
            begin
                s_nxt.busy = 1'b0;
                if (line)
                begin
                    s_nxt.bv = 1'b1;
                    s_nxt.bd = s_r.sh;
                    s_nxt.crc = crc_byte(s_r.crc, s_r.sh);
                end
            end
        end
    end

    // ********************
    // state register
    // ********************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_r <= '{sync: 3'h7, crc: rsc_pkg::CRC_INIT, default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign byte_valid = s_r.bv;
    assign byte_data = s_r.bd;
    assign frame_gap = s_r.gap;
    assign crc = s_r.crc;
endmodule

// File: rtl/rsc_top.sv
`timescale 1ns/1ps
// Contract
// - keypad run source when selector 0, default
// - selector 1 follows external contact input
// - forward and reverse keys start keypad runs
// - reverse inhibit refuses reverse commands
// - stop uses chosen method, ramp default
// - link function bit 1 enables operation; frequency bit has no effect
// - default station 1, 9600 8N1
// - command word bits: forward, reverse
// - zero word written stops drive
// - frames end with checked crc16
// - detach of active keypad stops, alarms
// - run lamp after forward/reverse key
// - show run state and operation mode
// - backlight on key/power, off after 5 minutes
// - reset cancels input, clears trip on alarm screen
// - stop+reset toggles frequency source local/remote
// - stop+up toggles jogging mode
module rsc_top #(
    parameter int BIT_CYCLES = rsc_pkg::BIT_CYCLES,
    parameter longint BACKLIGHT_CYCLES = rsc_pkg::BACKLIGHT_CYCLES
)(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic rxd,
    input rsc_pkg::rsc_keys_t keys,
    input wire logic keypad_present,
    input wire logic contact_run,
    input wire logic contact_rev,
    input rsc_pkg::rsc_cfg_t cfg_in,
    input wire logic cfg_load,
    input wire logic alarm_screen,
    output logic run_fwd,
    output logic run_rev,
    output logic coast_stop,
    output logic run_led,
    output logic backlight,
    output logic keypad_alarm,
    output logic trip_clear,
    output logic input_cancel,
    output rsc_pkg::rsc_run_t run_state,
    output rsc_pkg::rsc_mode_t op_mode,
    output logic [1:0] run_source_select,
    output logic [3:0] frequency_source_select,
    output logic [15:0] operation_command_word
);
    typedef struct packed
    {
        logic [2:0] pres_s;
        logic [2:0] crun_s;
        logic [2:0] crev_s;
        logic [17:0] keys_s;
        logic pres;
        logic crun;
        logic crev;
        rsc_pkg::rsc_keys_t k;
        rsc_pkg::rsc_keys_t kprev;
        rsc_pkg::rsc_cfg_t cfg;
        logic jogging_mode;
        logic kfwd;
        logic krev;
        logic alarm;
        logic [15:0] cmd;
        logic [3:0] nbytes;
        logic [5:0][7:0] fr;
        logic [39:0] bl_cnt;
        logic bl;
        rsc_pkg::rsc_run_t st;
        rsc_pkg::rsc_mode_t mode;
        logic coast;
        logic tclr;
        logic icancel;
    } rsc_st_t;

    rsc_st_t s_r, s_nxt;
    logic byte_valid;
    logic [7:0] byte_data;
    logic frame_gap;
    logic [15:0] crc;

    // ********************
    // serial receiver
    // ********************
    rsc_rx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_rx (
        .clock(clock),
        .reset_n(reset_n),
        .rxd(rxd),
        .byte_valid(byte_valid),
        .byte_data(byte_data),
        .frame_gap(frame_gap),
        .crc(crc)
    );

    // stable once last two stages agree
    function automatic logic settle(input logic [2:0] sh, input logic old);
        return (sh[2] == sh[1]) ? sh[2] : old;
    endfunction

    // key pressed this cycle
    function automatic logic rose(input logic now, input logic was);
        return now & ~was;
    endfunction

    // ********************
    // next state
    // ********************
    always_comb
    begin
        logic keypad_src;
        logic any_key;
        logic stop_req;
        logic fwd_req;
        logic rev_req;
        logic [15:0] w;
        s_nxt = s_r;
        keypad_src = 1'b0;
        any_key = 1'b0;
        stop_req = 1'b0;
        fwd_req = 1'b0;
        rev_req = 1'b0;
        w = 16'h0000;
        s_nxt.tclr = 1'b0;
        s_nxt.icancel = 1'b0;
        // pin synchronisers
        s_nxt.pres_s = {s_r.pres_s[1:0], keypad_present};
        s_nxt.crun_s = {s_r.crun_s[1:0], contact_run};
        s_nxt.crev_s = {s_r.crev_s[1:0], contact_rev};
        s_nxt.pres = settle(s_r.pres_s, s_r.pres);
        s_nxt.crun = settle(s_r.crun_s, s_r.crun);
        s_nxt.crev = settle(s_r.crev_s, s_r.crev);
        for (int i = 0; i < 6; i++)
        begin
            s_nxt.keys_s[3*i +: 3] = {s_r.keys_s[3*i +: 2], keys[i]};
            s_nxt.k[i] = settle(s_r.keys_s[3*i +: 3], s_r.k[i]);
        end
        s_nxt.kprev = s_r.k;
        if (cfg_load)
        begin
            s_nxt.cfg = cfg_in;
        end
        keypad_src = (s_r.cfg.run_source_select == rsc_pkg::RUN_SRC_KEYPAD) ||
            (s_r.cfg.frequency_source_select == rsc_pkg::FREQ_SRC_KEYPAD);
        any_key = |(s_r.k & ~s_r.kprev);
        // keypad or contact commands
        if (s_r.cfg.run_source_select == rsc_pkg::RUN_SRC_KEYPAD)
        begin
            fwd_req = rose(s_r.k.forward_key, s_r.kprev.forward_key);
            rev_req = rose(s_r.k.reverse_key, s_r.kprev.reverse_key);
            stop_req = rose(s_r.k.stop_key, s_r.kprev.stop_key) &&
                !s_r.k.reset_key && !s_r.k.up_key;
            s_nxt.kfwd = fwd_req ? 1'b1 : (rev_req ? 1'b0 : s_r.kfwd);
            s_nxt.krev = rev_req && !fwd_req ? 1'b1 : (fwd_req ? 1'b0 : s_r.krev);
        end
        else if (s_r.cfg.run_source_select == rsc_pkg::RUN_SRC_CONTACT)
        begin
            fwd_req = s_r.crun && !s_r.crev;
            rev_req = s_r.crun && s_r.crev;
            stop_req = !s_r.crun;
        end
        // serial frame: addr, 06, reg hi/lo, data hi/lo, crc lo/hi
        if (frame_gap)
        begin
            s_nxt.nbytes = 4'h0;
        end
        else if (byte_valid && s_r.nbytes < 4'(rsc_pkg::FRAME_BYTES))
        begin
            if (s_r.nbytes < 4'h6)
            begin
                s_nxt.fr[s_r.nbytes[2:0]] = byte_data;
            end
            s_nxt.nbytes = s_r.nbytes + 4'h1;
            if (s_r.nbytes == 4'(rsc_pkg::FRAME_BYTES - 1) && crc == 16'h0000 &&
                s_r.fr[0] == s_r.cfg.station_addr &&
                s_r.fr[1] == rsc_pkg::FUNC_WRITE_SINGLE &&
                {s_r.fr[2], s_r.fr[3]} == rsc_pkg::CMD_WORD_ADDR)
            begin
                w = {s_r.fr[4], s_r.fr[5]};
                s_nxt.cmd = w;
                if (s_r.cfg.serial_link_function[rsc_pkg::LINK_FUNC_OP_BIT])
                begin
                    fwd_req = w[rsc_pkg::CMD_FWD_BIT] && !w[rsc_pkg::CMD_REV_BIT];
                    rev_req = w[rsc_pkg::CMD_REV_BIT] && !w[rsc_pkg::CMD_FWD_BIT];
                    stop_req = !fwd_req && !rev_req;
                end
            end
        end
        // refuse reverse when inhibited
        if (s_r.cfg.reverse_inhibit == rsc_pkg::REV_INHIBIT_ON)
        begin
            rev_req = 1'b0;
        end
        // keypad detached while active source
        if (!s_r.pres && keypad_src)
        begin
            s_nxt.alarm = 1'b1;
            stop_req = 1'b1;
        end
        // reset key
        if (rose(s_r.k.reset_key, s_r.kprev.reset_key) && !s_r.k.stop_key)
        begin
            s_nxt.icancel = 1'b1;
            if (alarm_screen)
            begin
                s_nxt.tclr = 1'b1;
                s_nxt.alarm = !s_r.pres && keypad_src;
            end
        end
        // local/remote toggle
        if (s_r.k.stop_key && rose(s_r.k.reset_key, s_r.kprev.reset_key))
        begin
            if (s_r.cfg.frequency_source_select == rsc_pkg::FREQ_SRC_KEYPAD)
            begin
                s_nxt.cfg.frequency_source_select = rsc_pkg::FREQ_SRC_REMOTE;
            end
            else if (s_r.cfg.frequency_source_select <= rsc_pkg::FREQ_SRC_REMOTE_MAX)
            begin
                s_nxt.cfg.frequency_source_select = rsc_pkg::FREQ_SRC_KEYPAD;
            end
        end
        // jogging toggle
        if (s_r.k.stop_key && rose(s_r.k.up_key, s_r.kprev.up_key))
        begin
            s_nxt.jogging_mode = !s_r.jogging_mode;
        end
        // run state, stop wins
        if (stop_req || s_r.alarm)
        begin
            s_nxt.st = rsc_pkg::ST_STOP;
            s_nxt.coast = (s_r.cfg.stop_method_select != rsc_pkg::STOP_RAMP);
            s_nxt.kfwd = 1'b0;
            s_nxt.krev = 1'b0;
        end
        else if (fwd_req)
        begin
            s_nxt.st = rsc_pkg::ST_FWD;
            s_nxt.coast = 1'b0;
        end
        else if (rev_req)
        begin
            s_nxt.st = rsc_pkg::ST_REV;
            s_nxt.coast = 1'b0;
        end
        // displayed mode
        if (s_r.jogging_mode)
        begin
            s_nxt.mode = rsc_pkg::MODE_JOG;
        end
        else if (s_r.cfg.serial_link_function[rsc_pkg::LINK_FUNC_OP_BIT])
        begin
            s_nxt.mode = rsc_pkg::MODE_SERIAL;
        end
        else if (s_r.cfg.run_source_select == rsc_pkg::RUN_SRC_KEYPAD)
        begin
            s_nxt.mode = rsc_pkg::MODE_KEYPAD;
        end
        else
        begin
            s_nxt.mode = rsc_pkg::MODE_TERMINAL;
        end
        // backlight timeout
        if (any_key)
        begin
            s_nxt.bl = 1'b1;
            s_nxt.bl_cnt = 40'(BACKLIGHT_CYCLES);
        end
        else if (s_r.bl_cnt != 40'h00_0000_0000)
        begin
            s_nxt.bl_cnt = s_r.bl_cnt - 40'h00_0000_0001;
        end
        else
        begin
            s_nxt.bl = 1'b0;
        end
    end

    // ********************
    // state register
    // ********************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_r <= '{
                pres_s: 3'h7, pres: 1'b1, keys_s: '0, k: '0, kprev: '0,
                cfg: '{run_source_select: rsc_pkg::RUN_SRC_RESET,
                    frequency_source_select: rsc_pkg::FREQ_SRC_RESET,
                    serial_link_function: rsc_pkg::LINK_FUNC_RESET,
                    reverse_inhibit: 1'b0, stop_method_select: rsc_pkg::STOP_RAMP,
                    station_addr: rsc_pkg::STATION_ADDR_RESET},
                cmd: rsc_pkg::CMD_WORD_RESET,
                bl_cnt: 40'(BACKLIGHT_CYCLES), bl: 1'b1,
                st: rsc_pkg::ST_STOP, mode: rsc_pkg::MODE_KEYPAD,
                default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ********************
    // outputs
    // ********************
    assign run_fwd = (s_r.st == rsc_pkg::ST_FWD);
    assign run_rev = (s_r.st == rsc_pkg::ST_REV);
    assign coast_stop = s_r.coast;
    assign run_led = s_r.kfwd | s_r.krev;
    assign backlight = s_r.bl;
    assign keypad_alarm = s_r.alarm;
    assign trip_clear = s_r.tclr;
    assign input_cancel = s_r.icancel;
    assign run_state = s_r.st;
    assign op_mode = s_r.mode;
    assign run_source_select = s_r.cfg.run_source_select;
    assign frequency_source_select = s_r.cfg.frequency_source_select;
    assign operation_command_word = s_r.cmd;
endmodule

// File: test/rsc_checker.sv
`timescale 1ns/1ps
// ****************
// run/stop checker
// ****************
module rsc_checker #(
    parameter longint BACKLIGHT_CYCLES = 100
)(
    input wire logic clock,
    input wire logic reset_n,
    input rsc_pkg::rsc_keys_t keys,
    input wire logic keypad_present,
    input wire logic contact_run,
    input rsc_pkg::rsc_cfg_t cfg_in,
    input wire logic cfg_load,
    input wire logic run_fwd,
    input wire logic run_rev,
    input wire logic backlight,
    input wire logic keypad_alarm,
    input wire logic trip_clear,
    input wire logic input_cancel,
    input rsc_pkg::rsc_run_t run_state,
    input rsc_pkg::rsc_mode_t op_mode,
    input wire logic [1:0] run_source_select
);
    logic inhib_r;
    logic [3:0] open_r;
    logic [63:0] idle_r;

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    // inhibit copy, contact open time and key idle time
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            inhib_r <= 1'b0;
            open_r <= 4'h0;
            idle_r <= 64'h0;
        end
        else
        begin
            if (cfg_load)
                inhib_r <= cfg_in.reverse_inhibit;
            open_r <= contact_run ? 4'h0 : (open_r == 4'hf ? open_r : open_r + 4'h1);
            idle_r <= (keys != '0) ? 64'h0 : idle_r + 64'h1;
        end
    end

    // steps of a stop
    sequence alarm_rise_s;
        $rose(keypad_alarm);
    endsequence
    sequence stopped_s;
        !run_fwd && !run_rev && run_state == rsc_pkg::ST_STOP;
    endsequence

    // direction, display and stop relations
    one_direction_a: assert property (!(run_fwd && run_rev))
        else $error("both directions");
    state_onehot_a: assert property ($onehot(run_state) && $onehot(op_mode))
        else $error("not one-hot");
    fwd_shown_a: assert property ($rose(run_fwd) |-> ##[0:1] run_state == rsc_pkg::ST_FWD)
        else $error("forward not shown");
    rev_refused_a: assert property (inhib_r |-> !$rose(run_rev))
        else $error("inhibited reverse");
    alarm_stops_a: assert property (alarm_rise_s |-> ##[0:2] stopped_s)
        else $error("alarm without stop");
    trip_pulse_a: assert property (trip_clear |=> !trip_clear)
        else $error("long trip clear");
    cancel_pulse_a: assert property (input_cancel |=> !input_cancel)
        else $error("long input cancel");
    trip_alarm_a: assert property (trip_clear && keypad_present |-> ##[0:2] !keypad_alarm)
        else $error("alarm not cleared");
    contact_open_a: assert property
        (run_source_select == rsc_pkg::RUN_SRC_CONTACT && open_r == 4'hf |-> stopped_s)
        else $error("running with contact open");
    light_on_a: assert property
        (idle_r >= 64'h10 && idle_r < BACKLIGHT_CYCLES - 16 |-> backlight)
        else $error("backlight off too early");
    light_off_a: assert property (idle_r > BACKLIGHT_CYCLES + 16 |-> !backlight)
        else $error("backlight on too long");
endmodule

bind rsc_top rsc_checker #(.BACKLIGHT_CYCLES(BACKLIGHT_CYCLES)) rsc_checker_i (
    .clock(clock), .reset_n(reset_n), .keys(keys), .keypad_present(keypad_present),
    .contact_run(contact_run), .cfg_in(cfg_in), .cfg_load(cfg_load), .run_fwd(run_fwd),
    .run_rev(run_rev), .backlight(backlight), .keypad_alarm(keypad_alarm),
    .trip_clear(trip_clear), .input_cancel(input_cancel), .run_state(run_state),
    .op_mode(op_mode), .run_source_select(run_source_select)
);

// File: test/rsc_link_master.sv
`timescale 1ns/1ps
// *************************
// serial link master model
// *************************
module rsc_link_master #(
    parameter int BIT_CYCLES = 16
)(
    input wire logic clock,
    output logic rxd
);
    // biased line rests at the mark level
    initial rxd = 1'b1;

    // one character: start, data lsb first, stop
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] sh;
        sh = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd = sh[i];
            repeat (BIT_CYCLES) @(negedge clock);
        end
    endtask

    // single-register write to the command word after an idle gap
    task automatic send_frame(input logic [7:0] a, input logic [15:0] w, input logic bad);
        logic [7:0] f [8];
        logic [15:0] c;
        f[0] = a;
        f[1] = rsc_pkg::FUNC_WRITE_SINGLE;
        {f[2], f[3]} = rsc_pkg::CMD_WORD_ADDR;
        {f[4], f[5]} = w;
        c = rsc_pkg::CRC_INIT;
        for (int i = 0; i < 6; i++)
        begin
            c = c ^ {8'h00, f[i]};
            for (int j = 0; j < 8; j++)
                c = c[0] ? ((c >> 1) ^ rsc_pkg::CRC_POLY) : (c >> 1);
        end
        {f[7], f[6]} = bad ? ~c : c;
        repeat (rsc_pkg::GAP_BITS * BIT_CYCLES) @(negedge clock);
        for (int i = 0; i < 8; i++)
            send_byte(f[i]);
    endtask
endmodule

// File: test/tb_rsc_top.sv
`timescale 1ns/1ps
// ***********************
// run/stop command bench
// ***********************
module tb_rsc_top;
    localparam rsc_pkg::rsc_keys_t K_FWD = 6'h20;
    localparam rsc_pkg::rsc_keys_t K_REV = 6'h10;
    localparam rsc_pkg::rsc_keys_t K_STOP = 6'h08;
    localparam rsc_pkg::rsc_keys_t K_RST = 6'h04;
    localparam rsc_pkg::rsc_keys_t K_UP = 6'h02;
    localparam rsc_pkg::rsc_run_t SS = rsc_pkg::ST_STOP;
    localparam rsc_pkg::rsc_run_t SF = rsc_pkg::ST_FWD;
    localparam rsc_pkg::rsc_run_t SR = rsc_pkg::ST_REV;
    logic clock, reset_n, rxd, keypad_present, contact_run, contact_rev, cfg_load, alarm_screen;
    logic run_fwd, run_rev, coast_stop, run_led, backlight, keypad_alarm, trip_clear, input_cancel;
    logic [1:0] run_source_select;
    logic [3:0] frequency_source_select;
    logic [15:0] operation_command_word;
    rsc_pkg::rsc_run_t run_state;
    rsc_pkg::rsc_mode_t op_mode;
    rsc_pkg::rsc_keys_t keys;
    rsc_pkg::rsc_cfg_t cfg_in;
    int bad_count, tests_run, k;

    rsc_top #(.BIT_CYCLES(16), .BACKLIGHT_CYCLES(100)) rsc_top_i (
        .clock(clock), .reset_n(reset_n), .rxd(rxd), .keys(keys), .keypad_present(keypad_present),
        .contact_run(contact_run), .contact_rev(contact_rev), .cfg_in(cfg_in), .cfg_load(cfg_load),
        .alarm_screen(alarm_screen), .run_fwd(run_fwd), .run_rev(run_rev), .coast_stop(coast_stop),
        .run_led(run_led), .backlight(backlight), .keypad_alarm(keypad_alarm),
        .trip_clear(trip_clear), .input_cancel(input_cancel), .run_state(run_state),
        .op_mode(op_mode), .run_source_select(run_source_select),
        .frequency_source_select(frequency_source_select),
        .operation_command_word(operation_command_word)
    );
    rsc_link_master #(.BIT_CYCLES(16)) rsc_link_master_i (.clock(clock), .rxd(rxd));

    // free-running clock
    always #10 clock = ~clock;

    // comparison, counting and closing report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // stimulus helpers, all changes at the falling edge
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic press(input rsc_pkg::rsc_keys_t kv, input rsc_pkg::rsc_run_t st);
        keys = kv;
        idle(8);
        keys = '0;
        idle(8);
        check(run_state, st, "run state");
    endtask
    task automatic combo(input rsc_pkg::rsc_keys_t kv);
        keys = K_STOP;
        idle(8);
        press(K_STOP | kv, SS);
    endtask
    task automatic set_cfg(input logic [1:0] src, input logic [3:0] fq, input logic [1:0] lnk,
                           input logic inh, input logic stm);
        cfg_in = '{src, fq, lnk, inh, stm, rsc_pkg::STATION_ADDR_RESET};
        cfg_load = 1'b1;
        idle(1);
        cfg_load = 1'b0;
        idle(8);
    endtask
    task automatic serial(input logic [7:0] a, input logic [15:0] w, input logic bad,
                          input rsc_pkg::rsc_run_t st, input logic [15:0] wexp);
        rsc_link_master_i.send_frame(a, w, bad);
        idle(4);
        check(run_state, st, "run state");
        check(operation_command_word, wexp, "command word");
    endtask

    // time limit for the whole run
    initial
    begin
        repeat (60000) @(posedge clock);
        check(1'b0, 1'b1, "time limit");
        print_verdict();
    end

    // main sequence
    initial
    begin
        clock = 1'b0;
        reset_n = 1'b0;
        keys = '0;
        keypad_present = 1'b1;
        contact_run = 1'b0;
        contact_rev = 1'b0;
        cfg_load = 1'b0;
        alarm_screen = 1'b0;
        cfg_in = '0;
        cfg_in.station_addr = rsc_pkg::STATION_ADDR_RESET;
        bad_count = 0;
        tests_run = 0;
        idle(3);
        reset_n = 1'b1;
        idle(6);
        check(run_source_select, rsc_pkg::RUN_SRC_RESET, "run source");
        check(operation_command_word, rsc_pkg::CMD_WORD_RESET, "command word");
        check(op_mode, rsc_pkg::MODE_KEYPAD, "mode");
        check(backlight, 1'b1, "backlight");
        idle(120);
        check(backlight, 1'b0, "backlight");
        press(K_FWD, SF);
        check(backlight, 1'b1, "backlight");
        check(run_led, 1'b1, "run lamp");
        press(K_STOP, SS);
        check(coast_stop, 1'b0, "coast stop");
        press(K_REV, SR);
        press(K_STOP, SS);
        set_cfg(2'h0, 4'h0, 2'h0, 1'b1, 1'b1);
        press(K_REV, SS);
        press(K_FWD, SF);
        keypad_present = 1'b0;
        idle(8);
        check(keypad_alarm, 1'b1, "keypad alarm");
        check(run_state, SS, "run state");
        check(coast_stop, 1'b1, "coast stop");
        keypad_present = 1'b1;
        alarm_screen = 1'b1;
        keys = K_RST;
        for (k = 0; k < 20 && trip_clear !== 1'b1; k++) @(posedge clock) #1;
        check(trip_clear, 1'b1, "trip clear");
        @(negedge clock);
        keys = '0;
        alarm_screen = 1'b0;
        idle(8);
        check(keypad_alarm, 1'b0, "keypad alarm");
        keys = K_RST;
        for (k = 0; k < 20 && input_cancel !== 1'b1; k++) @(posedge clock) #1;
        check(input_cancel, 1'b1, "input cancel");
        @(negedge clock);
        keys = '0;
        idle(8);
        combo(K_RST);
        check(frequency_source_select, rsc_pkg::FREQ_SRC_REMOTE, "freq source");
        combo(K_RST);
        check(frequency_source_select, rsc_pkg::FREQ_SRC_KEYPAD, "freq source");
        combo(K_UP);
        check(op_mode, rsc_pkg::MODE_JOG, "mode");
        combo(K_UP);
        check(op_mode, rsc_pkg::MODE_KEYPAD, "mode");
        set_cfg(2'h1, 4'h3, 2'h0, 1'b0, 1'b0);
        check(op_mode, rsc_pkg::MODE_TERMINAL, "mode");
        press(K_FWD, SS);
        contact_run = 1'b1;
        idle(8);
        check(run_state, SF, "run state");
        contact_rev = 1'b1;
        idle(8);
        check(run_state, SR, "run state");
        keypad_present = 1'b0;
        idle(8);
        check(keypad_alarm, 1'b0, "keypad alarm");
        check(run_state, SR, "run state");
        keypad_present = 1'b1;
        contact_run = 1'b0;
        contact_rev = 1'b0;
        idle(8);
        check(run_state, SS, "run state");
        set_cfg(2'h0, 4'h3, 2'h2, 1'b0, 1'b0);
        check(op_mode, rsc_pkg::MODE_SERIAL, "mode");
        serial(8'h01, 16'h0001, 1'b0, SF, 16'h0001);
        serial(8'h01, 16'h0003, 1'b0, SS, 16'h0003);
        serial(8'h01, 16'h0002, 1'b0, SR, 16'h0002);
        serial(8'h01, 16'h0000, 1'b0, SS, 16'h0000);
        serial(8'h01, 16'h0001, 1'b1, SS, 16'h0000);
        serial(8'h02, 16'h0001, 1'b0, SS, 16'h0000);
        set_cfg(2'h0, 4'h3, 2'h1, 1'b0, 1'b0);
        serial(8'h01, 16'h0001, 1'b0, SS, 16'h0001);
        set_cfg(2'h0, 4'h3, 2'h0, 1'b0, 1'b0);
        serial(8'h01, 16'h0002, 1'b0, SS, 16'h0002);
        set_cfg(2'h0, 4'h3, 2'h3, 1'b1, 1'b0);
        serial(8'h01, 16'h0002, 1'b0, SS, 16'h0002);
        serial(8'h01, 16'h0001, 1'b0, SF, 16'h0001);
        print_verdict();
    end
endmodule
